// ===== lane_ctl_pkg.sv
// Constants and types for the link sync and lane test pattern control block
// Contract
// [R1] Select bit 0 takes pins, 1 takes software
// [R2] Soft request 0 asserts, 1 releases; resets 0
// [R3] Soft request ignored while pins selected
// [R4] Pattern field low nibble, 0000 is normal
// [R5] Codes 0001 PRBS7, 0010 PRBS15
// [R6] 0101 ILA, 0110 ramp, 0111 K28.5, 1000 D21.5
// [R7] 1001 static low, 1010 static high
// [R8] Software avoids codes 0100 and 1011-1111
// [R9] Software disables link before changing settings
// [R10] 16-bit ramp step at 0x62/0x63, resets 0x0001
// [R11] Software never writes a zero ramp step
// [R12] Status bit 6 set only with data flowing
// [R13] Disabled link sends repeating 01010101 stream
// [R14] Receiver holds request four frames minimum
// [R15] Code 0011 selects PRBS23
package lane_ctl_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] ADDR_CTRL_TWO = 16'h0061;
  localparam logic [15:0] ADDR_RSTEP_LOW = 16'h0062;
  localparam logic [15:0] ADDR_RSTEP_HIGH = 16'h0063;
  localparam logic [15:0] ADDR_STATUS = 16'h006c;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam logic [15:0] RSTEP_RESET = 16'h0001;
  localparam int SYNC_SEL_BIT = 7;
  localparam int SOFT_SYNC_BIT = 6;
  localparam int LINK_UP_BIT = 6;
  localparam int TP_LSB = 0;
  localparam int TP_W = 4;
  localparam logic [3:0] TP_NORMAL = 4'h0;
  localparam logic [3:0] TP_PRBS7 = 4'h1;
  localparam logic [3:0] TP_PRBS15 = 4'h2;
  localparam logic [3:0] TP_PRBS23 = 4'h3;
  localparam logic [3:0] TP_ILA = 4'h5;
  localparam logic [3:0] TP_RAMP = 4'h6;
  localparam logic [3:0] TP_K28_5 = 4'h7;
  localparam logic [3:0] TP_D21_5 = 4'h8;
  localparam logic [3:0] TP_LOW = 4'h9;
  localparam logic [3:0] TP_HIGH = 4'ha;
  localparam logic [7:0] CHAR_K28_5 = 8'hbc;
  localparam logic [7:0] CHAR_K28_0 = 8'h1c;
  localparam logic [7:0] CHAR_K28_3 = 8'h7c;
  localparam logic [7:0] CHAR_D21_5 = 8'hb5;
  localparam logic [7:0] ALT_PATTERN = 8'h55;
  localparam logic [7:0] ALL_LOW = 8'h00;
  localparam logic [7:0] ALL_HIGH = 8'hff;
  localparam int OCTET_CNT_W = 6;
  localparam int SYNC_MIN_FRAMES = 4;
  localparam logic [3:0] SYNC_MIN_CNT = 4'h4;
  localparam logic [1:0] ILA_LAST_MF = 2'h3;
  localparam logic [22:0] PRBS_SEED = 23'h7fffff;

  typedef enum logic [1:0] {
    LINK_OFF = 2'b00,
    LINK_CGS = 2'b01,
    LINK_ILA = 2'b10,
    LINK_DATA = 2'b11
  } link_state_t;

  typedef struct packed {
    logic [7:0] octet;
    logic is_k;
    logic raw;
  } lane_word_t;

  typedef struct packed {
    logic [7:0] ctrl_two;
    logic [15:0] rstep;
    logic pin_s1;
    logic pin_s2;
    logic sync_req;
    link_state_t lstate;
    logic [3:0] req_cnt;
    logic [OCTET_CNT_W-1:0] octet_cnt;
    logic [1:0] ila_mf;
    logic [22:0] prbs;
    logic [15:0] ramp;
    logic [7:0] sample_low;
    lane_word_t lane;
    logic [7:0] rdata;
    logic rvalid;
    logic link_up;
  } ctl_state_t;

  localparam ctl_state_t STATE_RESET = '{
    ctrl_two: CTRL_TWO_RESET,
    rstep: RSTEP_RESET,
    pin_s1: 1'b1,
    pin_s2: 1'b1,
    sync_req: 1'b0,
    lstate: LINK_OFF,
    req_cnt: 4'h0,
    octet_cnt: '0,
    ila_mf: 2'h0,
    prbs: PRBS_SEED,
    ramp: 16'h0000,
    sample_low: 8'h00,
    lane: '{octet: 8'h00, is_k: 1'b0, raw: 1'b1},
    rdata: 8'h00,
    rvalid: 1'b0,
    link_up: 1'b0
  };
endpackage

// ===== serial_link_sync_and_test_control.sv
// Link sync source selection, lane test pattern generation and link status
`timescale 1ns/1ns
module serial_link_sync_and_test_control (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic link_enable_in,
  input wire logic sync_pin_n_in,
  input wire logic [13:0] sample_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [lane_ctl_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic [7:0] lane_octet_out,
  output logic lane_is_k_out,
  output logic lane_raw_out,
  output logic sync_request_out,
  output logic link_established_out
);

  lane_ctl_pkg::ctl_state_t st_r;
  lane_ctl_pkg::ctl_state_t st_nxt;

  // Advance the selected PRBS generator by eight bits
  function automatic logic [22:0] prbs_adv(input logic [22:0] s, input logic [3:0] mode);
    logic [22:0] v;
    logic fb;
    v = s;
    fb = 1'b0;
    for (int i = 0; i < 8; i++) begin
      unique case (mode)
        lane_ctl_pkg::TP_PRBS7: fb = v[6] ^ v[5];
        lane_ctl_pkg::TP_PRBS15: fb = v[14] ^ v[13];
        default: fb = v[22] ^ v[17];
      endcase
      v = {v[21:0], fb};
    end
    return v;
  endfunction

  function automatic lane_ctl_pkg::lane_word_t chr(input logic [7:0] o, input logic k, input logic r);
    lane_ctl_pkg::lane_word_t w;
    w.octet = o;
    w.is_k = k;
    w.raw = r;
    return w;
  endfunction

  always_comb begin
    logic sel_soft;
    logic req_n;
    logic req;
    logic frame_end;
    logic mf_end;
    logic mf_start;
    logic [3:0] mode;
    logic [22:0] prbs_n;
    lane_ctl_pkg::lane_word_t data_w;
    lane_ctl_pkg::lane_word_t ila_w;
    st_nxt = st_r;
    req_n = 1'b1;
    req = 1'b0;
    ila_w = '0;
    data_w = '0;
    sel_soft = st_r.ctrl_two[lane_ctl_pkg::SYNC_SEL_BIT];
    mode = st_r.ctrl_two[lane_ctl_pkg::TP_LSB +: lane_ctl_pkg::TP_W]; // R4
    frame_end = st_r.octet_cnt[0];
    mf_end = &st_r.octet_cnt;
    mf_start = ~|st_r.octet_cnt;
    prbs_n = prbs_adv(st_r.prbs, mode);

    // Pin request crosses into the core clock
    st_nxt.pin_s1 = sync_pin_n_in;
    st_nxt.pin_s2 = st_r.pin_s1;

    // Software bit only counts when selected
    if (sel_soft) begin // R1
      req_n = st_r.ctrl_two[lane_ctl_pkg::SOFT_SYNC_BIT]; // R2
    end else begin
      req_n = st_r.pin_s2; // R3
    end
    req = ~req_n;
    st_nxt.sync_req = req;

    st_nxt.octet_cnt = st_r.octet_cnt + 1'b1;

    // Request must persist several frames before it restarts the link
    if (!req) begin
      st_nxt.req_cnt = 4'h0;
    end else if (frame_end && st_r.req_cnt != lane_ctl_pkg::SYNC_MIN_CNT) begin
      st_nxt.req_cnt = st_r.req_cnt + 4'h1; // R14
    end

    if (!link_enable_in) begin
      st_nxt.lstate = lane_ctl_pkg::LINK_OFF;
    end else begin
      unique case (st_r.lstate)
        lane_ctl_pkg::LINK_OFF: begin
          st_nxt.lstate = lane_ctl_pkg::LINK_CGS;
        end
        lane_ctl_pkg::LINK_CGS: begin
          if ((!req || mode == lane_ctl_pkg::TP_ILA) && mf_end) begin
            st_nxt.lstate = lane_ctl_pkg::LINK_ILA;
            st_nxt.ila_mf = 2'h0;
          end
        end
        lane_ctl_pkg::LINK_ILA: begin
          if (mf_end) begin
            if (st_r.ila_mf != lane_ctl_pkg::ILA_LAST_MF) begin
              st_nxt.ila_mf = st_r.ila_mf + 2'h1;
            end else if (mode == lane_ctl_pkg::TP_ILA) begin
              st_nxt.ila_mf = 2'h0; // R6
            end else begin
              st_nxt.lstate = lane_ctl_pkg::LINK_DATA;
            end
          end
        end
        lane_ctl_pkg::LINK_DATA: begin
          if (mode == lane_ctl_pkg::TP_ILA && mf_end) begin
            st_nxt.lstate = lane_ctl_pkg::LINK_ILA;
            st_nxt.ila_mf = 2'h0;
          end
        end
      endcase
      if (st_r.req_cnt == lane_ctl_pkg::SYNC_MIN_CNT && st_r.lstate != lane_ctl_pkg::LINK_CGS &&
          mode != lane_ctl_pkg::TP_ILA) begin
        st_nxt.lstate = lane_ctl_pkg::LINK_CGS; // R14
      end
    end

    // Initial lane alignment: start and end markers around a counting fill
    if (mf_start) begin
      ila_w = chr(lane_ctl_pkg::CHAR_K28_0, 1'b1, 1'b0);
    end else if (mf_end) begin
      ila_w = chr(lane_ctl_pkg::CHAR_K28_3, 1'b1, 1'b0);
    end else begin
      ila_w = chr({2'b00, st_r.octet_cnt}, 1'b0, 1'b0);
    end

    // Converter samples go out high octet first, one per two-octet frame
    if (!frame_end) begin
      data_w = chr(sample_in[13:6], 1'b0, 1'b0);
      st_nxt.sample_low = {sample_in[5:0], 2'b00};
    end else begin
      data_w = chr(st_r.sample_low, 1'b0, 1'b0);
    end

    if (mode == lane_ctl_pkg::TP_PRBS7 || mode == lane_ctl_pkg::TP_PRBS15 ||
        mode == lane_ctl_pkg::TP_PRBS23) begin
      st_nxt.prbs = prbs_n;
    end else begin
      st_nxt.prbs = lane_ctl_pkg::PRBS_SEED;
    end

    if (mode == lane_ctl_pkg::TP_RAMP && link_enable_in) begin
      if (frame_end) begin
        st_nxt.ramp = st_r.ramp + st_r.rstep; // R10
      end
    end else begin
      st_nxt.ramp = 16'h0000;
    end

    if (!link_enable_in) begin
      st_nxt.lane = chr(lane_ctl_pkg::ALT_PATTERN, 1'b0, 1'b1); // R13
    end else begin
      unique case (mode)
        lane_ctl_pkg::TP_NORMAL: begin
          unique case (st_r.lstate)
            lane_ctl_pkg::LINK_ILA: st_nxt.lane = ila_w;
            lane_ctl_pkg::LINK_DATA: st_nxt.lane = data_w;
            default: st_nxt.lane = chr(lane_ctl_pkg::CHAR_K28_5, 1'b1, 1'b0);
          endcase
        end
        lane_ctl_pkg::TP_PRBS7, lane_ctl_pkg::TP_PRBS15: begin
          st_nxt.lane = chr(prbs_n[7:0], 1'b0, 1'b1); // R5
        end
        lane_ctl_pkg::TP_PRBS23: begin
          st_nxt.lane = chr(prbs_n[7:0], 1'b0, 1'b1); // R15
        end
        lane_ctl_pkg::TP_ILA: begin
          if (st_r.lstate == lane_ctl_pkg::LINK_ILA) begin
            st_nxt.lane = ila_w; // R6
          end else begin
            st_nxt.lane = chr(lane_ctl_pkg::CHAR_K28_5, 1'b1, 1'b0);
          end
        end
        lane_ctl_pkg::TP_RAMP: begin
          st_nxt.lane = chr(frame_end ? st_r.ramp[7:0] : st_r.ramp[15:8], 1'b0, 1'b0); // R6
        end
        lane_ctl_pkg::TP_K28_5: begin
          st_nxt.lane = chr(lane_ctl_pkg::CHAR_K28_5, 1'b1, 1'b0); // R6
        end
        lane_ctl_pkg::TP_D21_5: begin
          st_nxt.lane = chr(lane_ctl_pkg::CHAR_D21_5, 1'b0, 1'b0); // R6
        end
        lane_ctl_pkg::TP_HIGH: begin
          st_nxt.lane = chr(lane_ctl_pkg::ALL_HIGH, 1'b0, 1'b1); // R7
        end
        default: begin
          // Static low, also taken for unused codes
          st_nxt.lane = chr(lane_ctl_pkg::ALL_LOW, 1'b0, 1'b1); // R7
        end
      endcase
    end

    st_nxt.link_up = link_enable_in && mode == lane_ctl_pkg::TP_NORMAL &&
                     st_r.lstate == lane_ctl_pkg::LINK_DATA &&
                     st_nxt.lstate == lane_ctl_pkg::LINK_DATA; // R12

    if (reg_wr_in) begin
      unique case (reg_addr_in)
        lane_ctl_pkg::ADDR_CTRL_TWO: st_nxt.ctrl_two = reg_wdata_in;
        lane_ctl_pkg::ADDR_RSTEP_LOW: st_nxt.rstep[7:0] = reg_wdata_in; // R10
        lane_ctl_pkg::ADDR_RSTEP_HIGH: st_nxt.rstep[15:8] = reg_wdata_in; // R10
        default: st_nxt.ctrl_two = st_r.ctrl_two;
      endcase
    end

    st_nxt.rvalid = reg_rd_in;
    st_nxt.rdata = 8'h00;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        lane_ctl_pkg::ADDR_CTRL_TWO: st_nxt.rdata = st_r.ctrl_two;
        lane_ctl_pkg::ADDR_RSTEP_LOW: st_nxt.rdata = st_r.rstep[7:0];
        lane_ctl_pkg::ADDR_RSTEP_HIGH: st_nxt.rdata = st_r.rstep[15:8];
        lane_ctl_pkg::ADDR_STATUS: st_nxt.rdata[lane_ctl_pkg::LINK_UP_BIT] = st_r.link_up; // R12
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_r <= lane_ctl_pkg::STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_out = st_r.rdata;
  assign reg_rvalid_out = st_r.rvalid;
  assign lane_octet_out = st_r.lane.octet;
  assign lane_is_k_out = st_r.lane.is_k;
  assign lane_raw_out = st_r.lane.raw;
  assign sync_request_out = st_r.sync_req;
  assign link_established_out = st_r.link_up;

endmodule

// ===== lane_ctl_sva.sv
// Port-level checker for link sync and lane test pattern control
`timescale 1ns/1ns
module lane_ctl_sva (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic link_enable_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic [7:0] lane_octet_out,
  input wire logic lane_is_k_out,
  input wire logic lane_raw_out,
  input wire logic sync_request_out,
  input wire logic link_established_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_off; !link_enable_in [*2]; endsequence
  sequence s_up; $rose(link_established_out); endsequence
  property p_rd_answer; reg_rd_in |=> reg_rvalid_out; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_idle; !reg_rd_in |=> !reg_rvalid_out && reg_rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_off_alt; s_off |=> lane_octet_out == 8'h55 && lane_raw_out && !lane_is_k_out; endproperty
  a_off_alt: assert property (p_off_alt) else $error("disabled lane not alternating");
  property p_off_down; s_off |=> !link_established_out; endproperty
  a_off_down: assert property (p_off_down) else $error("link up while disabled");
  property p_up_data; s_up |-> !lane_is_k_out && !lane_raw_out && !sync_request_out; endproperty
  a_up_data: assert property (p_up_data) else $error("link up without data");
  property p_up_enabled; link_established_out |-> $past(link_enable_in, 2); endproperty
  a_up_enabled: assert property (p_up_enabled) else $error("link up without enable");
  property p_k_char; lane_is_k_out |-> lane_octet_out inside {8'hbc, 8'h1c, 8'h7c}; endproperty
  a_k_char: assert property (p_k_char) else $error("bad control character");
  property p_raw_not_k; lane_raw_out |-> !lane_is_k_out; endproperty
  a_raw_not_k: assert property (p_raw_not_k) else $error("raw octet flagged as control");
endmodule
bind serial_link_sync_and_test_control lane_ctl_sva sva_u (.core_clk_in, .reset_in, .link_enable_in,
  .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .lane_octet_out, .lane_is_k_out, .lane_raw_out,
  .sync_request_out, .link_established_out);

// ===== sync_receiver_model.sv
// Receiver model driving the active-low sync request pin
`timescale 1ns/1ns
module sync_receiver_model (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic want_sync_in,
  output logic sync_pin_n_out
);
  logic [3:0] hold_r;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      hold_r <= 4'h0;
      sync_pin_n_out <= 1'b1;
    end else if (want_sync_in && sync_pin_n_out) begin
      hold_r <= 4'h8;
      sync_pin_n_out <= 1'b0;
    end else begin
      if (hold_r != 4'h0) begin
        hold_r <= hold_r - 4'h1;
      end
      sync_pin_n_out <= !(want_sync_in || hold_r > 4'h1);
    end
  end
endmodule

// ===== serial_link_sync_and_test_control_bench.sv
// Self-checking bench for link sync and lane test pattern control
`timescale 1ns/1ns
module serial_link_sync_and_test_control_bench;
  logic core_clk_in, reset_in, link_enable_in, want_sync, sync_pin_n, reg_wr_in, reg_rd_in;
  logic [13:0] sample_in;
  logic [15:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, lane_octet_out;
  logic reg_rvalid_out, lane_is_k_out, lane_raw_out, sync_request_out, link_established_out;
  logic [31:0] lfsr_r = 32'h178c0;
  logic [7:0] regs [int];
  logic [7:0] o [6];
  logic [13:0] smp, smp_edge;
  int n_data;
  int num_errors = 0;
  int n_compared = 0;
  serial_link_sync_and_test_control dut_u (.core_clk_in, .reset_in, .link_enable_in,
    .sync_pin_n_in(sync_pin_n), .sample_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
    .reg_rdata_out, .reg_rvalid_out, .lane_octet_out, .lane_is_k_out, .lane_raw_out,
    .sync_request_out, .link_established_out);
  sync_receiver_model rx_u (.core_clk_in, .reset_in, .want_sync_in(want_sync), .sync_pin_n_out(sync_pin_n));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
    if (regs.exists(a)) begin
      regs[a] = d;
    end
    @(negedge core_clk_in);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(negedge core_clk_in);
    reg_rd_in = 1'b0;
    check("read data", reg_rdata_out, exp);
    @(negedge core_clk_in);
  endtask
  task automatic set_mode(input logic [7:0] ctrl);
    link_enable_in = 1'b0;
    wr(16'h0061, ctrl);
    link_enable_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  always @(negedge core_clk_in) begin
    lfsr_r <= {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
    sample_in <= lfsr_r[13:0];
  end
  always @(posedge core_clk_in) begin
    smp_edge <= sample_in;
  end
  initial begin
    #(100 * 20000);
    num_errors++;
    complete_run();
  end
  initial begin
    {reset_in, link_enable_in, want_sync, reg_wr_in, reg_rd_in} = 5'h10;
    reg_addr_in = 16'h0000;
    reg_wdata_in = 8'h00;
    sample_in = 14'h0000;
    regs[16'h61] = 8'h00;
    regs[16'h62] = 8'h01;
    regs[16'h63] = 8'h00;
    repeat (6) @(negedge core_clk_in);
    reset_in = 1'b0;
    repeat (3) @(negedge core_clk_in);
    foreach (regs[a]) rd(16'(a), regs[a]);
    wr(16'h0070, 8'h5a);
    wr(16'h006c, 8'hff);
    rd(16'h0070, 8'h00);
    rd(16'h006c, 8'h00);
    check("idle lane", {lane_octet_out, lane_raw_out}, 9'h0ab);
    for (int i = 0; i < 8; i++) begin
      want_sync = i[0];
      wr(16'h0061, {i[2], i[1], 6'h00});
      repeat (14) @(negedge core_clk_in);
      check("sync request", sync_request_out, i[2] ? !i[1] : i[0]);
    end
    want_sync = 1'b0;
    for (int c = 4; c < 16; c++) begin
      if (c == 5 || c == 6) continue;
      set_mode(8'(c));
      check("lane octet", lane_octet_out, c == 7 ? 8'hbc : c == 8 ? 8'hb5 : c == 10 ? 8'hff : 8'h00);
      check("lane flags", {lane_is_k_out, lane_raw_out}, c == 7 ? 2'b10 : c == 8 ? 2'b00 : 2'b01);
    end
    for (int c = 1; c < 4; c++) begin
      set_mode(8'(c));
      check("prbs raw", lane_raw_out, 1'b1);
    end
    set_mode(8'h01);
    o[0] = lane_octet_out;
    repeat (127) @(negedge core_clk_in);
    check("prbs7 period", lane_octet_out, o[0]);
    link_enable_in = 1'b0;
    wr(16'h0062, lfsr_r[7:0] | 8'h01);
    wr(16'h0063, lfsr_r[15:8]);
    rd(16'h0062, regs[16'h62]);
    rd(16'h0063, regs[16'h63]);
    set_mode(8'h06);
    foreach (o[k]) begin
      o[k] = lane_octet_out;
      @(negedge core_clk_in);
    end
    check("ramp step", ({o[2], o[3]} - {o[0], o[1]} == {regs[16'h63], regs[16'h62]})
      || ({o[3], o[4]} - {o[1], o[2]} == {regs[16'h63], regs[16'h62]}), 1'b1);
    set_mode(8'h00);
    for (int i = 0; i < 600 && link_established_out !== 1'b1; i++) @(negedge core_clk_in);
    check("link up", {link_established_out, sync_request_out}, 2'b10);
    n_data = 0;
    for (int i = 0; i < 8; i++) begin
      o[0] = lane_octet_out;
      smp = smp_edge;
      @(negedge core_clk_in);
      if (o[0] == smp[13:6] && lane_octet_out == {smp[5:0], 2'b00} && !lane_is_k_out && !lane_raw_out) begin
        n_data++;
      end
    end
    check("data octets", n_data, 16'h0004);
    rd(16'h006c, 8'h40);
    want_sync = 1'b1;
    @(negedge core_clk_in);
    want_sync = 1'b0;
    for (int i = 0; i < 60 && link_established_out !== 1'b0; i++) @(negedge core_clk_in);
    rd(16'h006c, 8'h00);
    link_enable_in = 1'b0;
    repeat (3) @(negedge core_clk_in);
    check("disabled lane", {lane_octet_out, lane_raw_out}, 9'h0ab);
    complete_run();
  end
endmodule
